// *** rtl/psr_config_regs.v ***
// Purpose: power-down, sync and reference configuration registers
// Assumes: serial port pins sampled by sys_clk_i, sclk slower than sys_clk/4
// Notes: all outputs registered; frame is r/w bit, 7-bit address, 8-bit data
//
// Behaviour
// - output_buffer_power bit 5 set turns the frame clock output buffer off.
// - output_buffer_power bit 4 set turns the bit clock output buffer off.
// - bits 3..0 turn off lanes A1, A0, B1, B0 respectively.
// - lane 1 buffers never switch off by output mode, only by bits.
// - lane B0 buffer never switches off in half-lane mode, only by bit.
// - mask bit 3 zero lets global sleep turn the clock input buffer off.
// - mask bit 2 zero lets global sleep turn the reference amplifier off.
// - mask bit 1 one lets global sleep turn the bandgap off.
// - control bit 7 picks pin role: 0 sleep, 1 sync on rising edge.
// - changing control bit 6 syncs only while bit 5 set; host clears it.
// - control bit 5 set takes sync from the register instead of the pin.
// - control bit 3 zero: pin picks reference; one: bits 2-1 and bit 0 do.
// - reference field: 00 internal, 01 external buffered, 10 external.
// - bit 0 with bit 3 set selects single-ended clock, differential off.
// - global sleep powers blocks down as the mask register says.
// - delay register bit 2 turns sampling delay off; host uses it below 40 MSPS.
// - delay register bit 0 drives auto-zero, polarity per speed grade.
`timescale 1ns/1ns
`default_nettype none
`include "psr_defines.vh"

module psr_config_regs #(
    parameter AZ_ACTIVE_HIGH = 1'b1
) (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire spi_sclk_i,
    input wire spi_cs_n_i,
    input wire spi_sdi_i,
    output reg spi_sdo_o,
    output reg spi_sdo_oe_o,
    input wire sync_or_sleep_pin_i,
    input wire reference_buffer_pin_i,
    input wire global_sleep_i,
    output reg frame_clock_out_off_o,
    output reg bit_clock_out_off_o,
    output reg lane_a1_off_o,
    output reg lane_a0_off_o,
    output reg lane_b1_off_o,
    output reg lane_b0_off_o,
    output reg sleep_active_o,
    output reg clock_buffer_off_o,
    output reg reference_amplifier_off_o,
    output reg bandgap_off_o,
    output reg sync_pulse_o,
    output reg [1:0] reference_source_select_o,
    output reg single_ended_clock_select_o,
    output reg diff_clock_buffer_off_o,
    output reg sampling_delay_off_o,
    output reg auto_zero_control_o,
    output reg auto_zero_on_o
);

    // ======================================================================
    // pin synchronisers: sclk, cs_n, sdi, sync/sleep pin, reference pin
    localparam NSYNC = 5;

    wire [NSYNC-1:0] pins_raw;
    reg [NSYNC-1:0] meta_r;
    reg [NSYNC-1:0] pins_r;

    assign pins_raw = {reference_buffer_pin_i, sync_or_sleep_pin_i,
                       spi_sdi_i, spi_cs_n_i, spi_sclk_i};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge sys_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_r[gi] <= (gi == 1) ? 1'b1 : 1'b0;
                    pins_r[gi] <= (gi == 1) ? 1'b1 : 1'b0;
                end else if (ce_i) begin
                    meta_r[gi] <= pins_raw[gi];
                    pins_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate

    wire sclk_s;
    wire cs_n_s;
    wire sdi_s;
    wire pin_s;
    wire refpin_s;

    assign sclk_s = pins_r[0];
    assign cs_n_s = pins_r[1];
    assign sdi_s = pins_r[2];
    assign pin_s = pins_r[3];
    assign refpin_s = pins_r[4];

    // ======================================================================
    // serial port edges
    reg sclk_d_r;
    reg pin_d_r;

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_d_r <= 1'b0;
            pin_d_r <= 1'b0;
        end else if (ce_i) begin
            sclk_d_r <= sclk_s;
            pin_d_r <= pin_s;
        end
    end

    wire sclk_rise;
    wire sclk_fall;

    assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s;

    // ======================================================================
    // serial frame shifter
    reg [4:0] bit_cnt_r;
    reg [15:0] shift_r;
    reg [7:0] out_r;
    reg rd_r;
    reg wr_stb_r;
    reg [6:0] wr_addr_r;
    reg [7:0] wr_data_r;
    reg [7:0] rd_data;

    wire [15:0] shift_nxt;
    wire [4:0] cnt_nxt;

    assign shift_nxt = {shift_r[14:0], sdi_s};
    assign cnt_nxt = bit_cnt_r + 5'd1;

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt_r <= 5'd0;
            shift_r <= 16'h0000;
            out_r <= 8'h00;
            rd_r <= 1'b0;
            wr_stb_r <= 1'b0;
            wr_addr_r <= 7'h00;
            wr_data_r <= 8'h00;
            spi_sdo_o <= 1'b0;
            spi_sdo_oe_o <= 1'b0;
        end else if (ce_i) begin
            wr_stb_r <= 1'b0;
            if (cs_n_s) begin
                bit_cnt_r <= 5'd0;
                rd_r <= 1'b0;
                spi_sdo_oe_o <= 1'b0;
                spi_sdo_o <= 1'b0;
            end else if (sclk_rise && bit_cnt_r < `PSR_FRAME_BITS) begin
                shift_r <= shift_nxt;
                bit_cnt_r <= cnt_nxt;
                if (cnt_nxt == `PSR_HEAD_BITS) begin
                    rd_r <= shift_nxt[`PSR_POS_RD_FLAG];
                    out_r <= rd_data;
                end
                if (cnt_nxt == `PSR_FRAME_BITS && !rd_r) begin
                    wr_stb_r <= 1'b1;
                    wr_addr_r <= shift_nxt[14:8];
                    wr_data_r <= shift_nxt[7:0];
                end
            end else if (sclk_fall && rd_r && bit_cnt_r < `PSR_FRAME_BITS) begin
                spi_sdo_oe_o <= 1'b1;
                spi_sdo_o <= out_r[7];
                out_r <= {out_r[6:0], 1'b0};
            end
        end
    end

    // ======================================================================
    // register storage, reserved bits kept as written
    reg [7:0] out_pwr_r;
    reg [7:0] mask_r;
    reg [7:0] ctl_r;
    reg [7:0] dly_r;

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_pwr_r <= `PSR_RST_OUT_PWR;
            mask_r <= `PSR_RST_MASK;
            ctl_r <= `PSR_RST_CTL;
            dly_r <= `PSR_RST_DLY;
        end else if (ce_i && wr_stb_r) begin
            if (wr_addr_r == `PSR_OFS_OUT_PWR) begin
                out_pwr_r <= wr_data_r;
            end else if (wr_addr_r == `PSR_OFS_MASK) begin
                mask_r <= wr_data_r;
            end else if (wr_addr_r == `PSR_OFS_CTL) begin
                ctl_r <= wr_data_r;
            end else if (wr_addr_r == `PSR_OFS_DLY) begin
                dly_r <= wr_data_r;
            end
        end
    end

    // address taken from the header bits just shifted in
    wire [6:0] rd_addr;

    assign rd_addr = shift_nxt[6:0];

    always @* begin
        if (rd_addr == `PSR_OFS_OUT_PWR) begin
            rd_data = out_pwr_r;
        end else if (rd_addr == `PSR_OFS_MASK) begin
            rd_data = mask_r;
        end else if (rd_addr == `PSR_OFS_CTL) begin
            rd_data = ctl_r;
        end else if (rd_addr == `PSR_OFS_DLY) begin
            rd_data = dly_r;
        end else begin
            rd_data = 8'h00;
        end
    end

    // ======================================================================
    // sleep and sync decode
    wire pin_role_sync;
    wire reg_sync_en;
    wire pin_sleep;
    wire sleep_now;
    wire pin_rise;
    reg reg_sync_d_r;

    assign pin_role_sync = ctl_r[`PSR_POS_PIN_ROLE];
    assign reg_sync_en = ctl_r[`PSR_POS_REG_SYNC_EN];
    assign pin_sleep = pin_s & ~pin_role_sync;
    assign sleep_now = global_sleep_i | pin_sleep;
    assign pin_rise = pin_s & ~pin_d_r;

    wire reg_sync_edge;
    wire pin_sync_edge;

    // any change of the sync bit counts while bit 5 is set; it stays where the host left it
    assign reg_sync_edge = (ctl_r[`PSR_POS_REG_SYNC] ^ reg_sync_d_r) &
                           reg_sync_en;
    assign pin_sync_edge = pin_rise & pin_role_sync & ~reg_sync_en;

    // ======================================================================
    // reference and clock selection
    wire ref_by_reg;
    wire [1:0] ref_sel;

    assign ref_by_reg = ctl_r[`PSR_POS_REF_BY_REG];
    assign ref_sel = ref_by_reg ?
        ctl_r[`PSR_POS_REF_SEL_HI:`PSR_POS_REF_SEL_LO] :
        {1'b0, refpin_s};

    wire se_clock;

    assign se_clock = ref_by_reg & ctl_r[`PSR_POS_SE_CLOCK];

    // ======================================================================
    // registered outputs
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_sync_d_r <= 1'b0;
            frame_clock_out_off_o <= 1'b0;
            bit_clock_out_off_o <= 1'b0;
            lane_a1_off_o <= 1'b0;
            lane_a0_off_o <= 1'b0;
            lane_b1_off_o <= 1'b0;
            lane_b0_off_o <= 1'b0;
            sleep_active_o <= 1'b0;
            clock_buffer_off_o <= 1'b0;
            reference_amplifier_off_o <= 1'b0;
            bandgap_off_o <= 1'b0;
            sync_pulse_o <= 1'b0;
            reference_source_select_o <= 2'h0;
            single_ended_clock_select_o <= 1'b0;
            diff_clock_buffer_off_o <= 1'b0;
            sampling_delay_off_o <= 1'b0;
            auto_zero_control_o <= 1'b0;
            auto_zero_on_o <= 1'b0;
        end else if (ce_i) begin
            reg_sync_d_r <= ctl_r[`PSR_POS_REG_SYNC];
            frame_clock_out_off_o <= out_pwr_r[`PSR_POS_FRAME_CLOCK];
            bit_clock_out_off_o <= out_pwr_r[`PSR_POS_BIT_CLOCK];
            // lane buffers follow their bits alone, whatever the lane mode
            lane_a1_off_o <= out_pwr_r[`PSR_POS_LANE_A1];
            lane_a0_off_o <= out_pwr_r[`PSR_POS_LANE_A0];
            lane_b1_off_o <= out_pwr_r[`PSR_POS_LANE_B1];
            lane_b0_off_o <= out_pwr_r[`PSR_POS_LANE_B0];
            sleep_active_o <= sleep_now;
            clock_buffer_off_o <= sleep_now &
                ~mask_r[`PSR_POS_KEEP_CLKBUF];
            reference_amplifier_off_o <= sleep_now &
                ~mask_r[`PSR_POS_KEEP_REFAMP];
            bandgap_off_o <= sleep_now &
                mask_r[`PSR_POS_BANDGAP_OFF];
            sync_pulse_o <= reg_sync_edge | pin_sync_edge;
            reference_source_select_o <= ref_sel;
            single_ended_clock_select_o <= se_clock;
            diff_clock_buffer_off_o <= se_clock;
            sampling_delay_off_o <= dly_r[`PSR_POS_DELAY_OFF];
            auto_zero_control_o <= dly_r[`PSR_POS_AUTO_ZERO];
            // speed grade decides whether a set bit means on or off
            auto_zero_on_o <= ~(dly_r[`PSR_POS_AUTO_ZERO] ^
                AZ_ACTIVE_HIGH);
        end
    end

endmodule

`default_nettype wire

// *** rtl/psr_defines.vh ***
// Purpose: constants of the power, sync and reference configuration bank
// Assumes: 7-bit register address, 8-bit register data, 16-bit serial frame
// Notes: included by psr_config_regs.v
`ifndef PSR_DEFINES_VH
`define PSR_DEFINES_VH

// ==========================================================================
// register offsets
`define PSR_OFS_OUT_PWR 7'h09
`define PSR_OFS_MASK 7'h0D
`define PSR_OFS_CTL 7'h0E
`define PSR_OFS_DLY 7'h11

// ==========================================================================
// reset values
`define PSR_RST_OUT_PWR 8'h00
`define PSR_RST_MASK 8'h00
`define PSR_RST_CTL 8'h00
`define PSR_RST_DLY 8'h00

// ==========================================================================
// output_buffer_power fields
`define PSR_POS_FRAME_CLOCK 5
`define PSR_POS_BIT_CLOCK 4
`define PSR_POS_LANE_A1 3
`define PSR_POS_LANE_A0 2
`define PSR_POS_LANE_B1 1
`define PSR_POS_LANE_B0 0

// ==========================================================================
// global_power_mask fields
`define PSR_POS_KEEP_CLKBUF 3
`define PSR_POS_KEEP_REFAMP 2
`define PSR_POS_BANDGAP_OFF 1

// ==========================================================================
// sync_reference_control fields
`define PSR_POS_PIN_ROLE 7
`define PSR_POS_REG_SYNC 6
`define PSR_POS_REG_SYNC_EN 5
`define PSR_POS_REF_BY_REG 3
`define PSR_POS_REF_SEL_HI 2
`define PSR_POS_REF_SEL_LO 1
`define PSR_POS_SE_CLOCK 0

// ==========================================================================
// sampling_delay_autozero fields
`define PSR_POS_DELAY_OFF 2
`define PSR_POS_AUTO_ZERO 0

// ==========================================================================
// serial frame layout: read flag, address, data, msb first
`define PSR_FRAME_BITS 5'd16
`define PSR_HEAD_BITS 5'd8
`define PSR_POS_RD_FLAG 7

`endif

// *** testbench/psr_config_checker.sv ***
// Purpose: port-level checks on the power, sync and reference bank
// Assumes: ce_i held high; host keeps select low well after the last clock
// Notes: bound to psr_config_regs at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module psr_config_checker #(
    parameter AZ_ACTIVE_HIGH = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sdo_oe_o,
    input wire logic global_sleep_i,
    input wire logic frame_clock_out_off_o,
    input wire logic bit_clock_out_off_o,
    input wire logic lane_a1_off_o,
    input wire logic lane_b0_off_o,
    input wire logic sleep_active_o,
    input wire logic clock_buffer_off_o,
    input wire logic reference_amplifier_off_o,
    input wire logic bandgap_off_o,
    input wire logic sync_pulse_o,
    input wire logic single_ended_clock_select_o,
    input wire logic diff_clock_buffer_off_o,
    input wire logic auto_zero_control_o,
    input wire logic auto_zero_on_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // ==========================================================
    // frame clock, bit clock, lane a1 and lane b0 buffers only move as a result of a serial write
    chk_frame_clk_write: assert property (
        $changed(frame_clock_out_off_o) |-> !$past(spi_cs_n_i, 4))
        else $error("frame clock buffer changed outside a frame");
    chk_bit_clk_write: assert property (
        $changed(bit_clock_out_off_o) |-> !$past(spi_cs_n_i, 4))
        else $error("bit clock buffer changed outside a frame");
    chk_lane_a1_write: assert property (
        $changed(lane_a1_off_o) |-> !$past(spi_cs_n_i, 4))
        else $error("lane a1 buffer changed outside a frame");
    chk_lane_b0_write: assert property (
        $changed(lane_b0_off_o) |-> !$past(spi_cs_n_i, 4))
        else $error("lane b0 buffer changed outside a frame");
    // serial data is only driven inside a selected frame
    chk_sdo_oe_frame: assert property (
        spi_sdo_oe_o |-> !$past(spi_cs_n_i, 3))
        else $error("serial data driven outside a frame");
    // ==========================================================
    // sleep and its mask
    chk_sleep_follows: assert property (
        global_sleep_i |=> sleep_active_o)
        else $error("global sleep not applied");
    chk_clkbuf_sleep: assert property (
        clock_buffer_off_o |-> sleep_active_o)
        else $error("clock buffer off while awake");
    chk_refamp_sleep: assert property (
        reference_amplifier_off_o |-> sleep_active_o)
        else $error("reference amplifier off while awake");
    chk_bandgap_sleep: assert property (
        bandgap_off_o |-> sleep_active_o)
        else $error("bandgap off while awake");
    // ==========================================================
    // sync, clock and auto-zero
    chk_sync_one_cycle: assert property (
        sync_pulse_o |=> !sync_pulse_o)
        else $error("sync pulse longer than one cycle");
    chk_se_clock_pair: assert property (
        single_ended_clock_select_o == diff_clock_buffer_off_o)
        else $error("single-ended select and differential off disagree");
    chk_auto_zero_pol: assert property (
        auto_zero_on_o == (auto_zero_control_o == AZ_ACTIVE_HIGH))
        else $error("auto-zero polarity wrong");
    cover property (sync_pulse_o);
    cover property (spi_sdo_oe_o);
    cover property (bandgap_off_o);
    cover property (single_ended_clock_select_o);
endmodule
bind psr_config_regs psr_config_checker #(.AZ_ACTIVE_HIGH(AZ_ACTIVE_HIGH)) i_chk (.*);
`default_nettype wire

// *** testbench/psr_host_model.sv ***
// Purpose: serial host that writes and reads the configuration bank
// Assumes: 16-bit frames, msb first, each serial clock level 6 system cycles
// Notes: serial clock stands low between frames; data line inverts when released
`timescale 1ns/1ns
`default_nettype none
module psr_host_model (
    input wire logic sys_clk_i,
    input wire logic sdo_i,
    output var logic sclk_o,
    output var logic cs_n_o,
    output var logic sdi_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    task automatic waitn(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    // nb below 16 raises select early, aborting the frame
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                        input int nb, output logic [7:0] q);
        logic [15:0] f;
        f = {rd, a, d};
        q = 8'h00;
        cs_n_o = 1'b0;
        waitn(4);
        for (int i = 15; i >= 16 - nb; i--) begin
            sdi_o = f[i];
            waitn(6);
            if (i < 8) q[i] = sdo_i;
            sclk_o = 1'b1;
            waitn(6);
            sclk_o = 1'b0;
        end
        waitn(6);
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        waitn(4);
    endtask
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Purpose: self-checking bench for the power, sync and reference bank
// Assumes: 20 MHz clock, inputs changed at the falling edge
// Notes: all traffic goes through the serial host model
`timescale 1ns/1ns
`default_nettype none
`include "psr_defines.vh"
module tb;
    logic sys_clk_i, rst_n_i, sclk, cs_n, sdi, pin, refpin, gsleep;
    wire [5:0] offs;
    wire [2:0] pwr;
    wire [1:0] refsel;
    wire sdo, oe, slp, syp, sec, dco, sdl, azc, azo;
    int failures = 0, checks = 0, cycles = 0, pulses = 0, oe_cycles = 0;
    logic [7:0] q;
    logic [2:0] mk;
    logic [6:0] ofs [4] = '{`PSR_OFS_OUT_PWR, `PSR_OFS_MASK, `PSR_OFS_CTL, `PSR_OFS_DLY};
    logic [7:0] seq [6] = '{8'h20, 8'h60, 8'h20, 8'h00, 8'h40, 8'h00};
    psr_config_regs i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo),
        .spi_sdo_oe_o(oe), .sync_or_sleep_pin_i(pin), .reference_buffer_pin_i(refpin),
        .global_sleep_i(gsleep), .frame_clock_out_off_o(offs[5]),
        .bit_clock_out_off_o(offs[4]), .lane_a1_off_o(offs[3]), .lane_a0_off_o(offs[2]),
        .lane_b1_off_o(offs[1]), .lane_b0_off_o(offs[0]), .sleep_active_o(slp),
        .clock_buffer_off_o(pwr[2]), .reference_amplifier_off_o(pwr[1]),
        .bandgap_off_o(pwr[0]), .sync_pulse_o(syp), .reference_source_select_o(refsel),
        .single_ended_clock_select_o(sec), .diff_clock_buffer_off_o(dco),
        .sampling_delay_off_o(sdl), .auto_zero_control_o(azc), .auto_zero_on_o(azo));
    psr_host_model i_host (.sys_clk_i(sys_clk_i), .sdo_i(sdo), .sclk_o(sclk),
        .cs_n_o(cs_n), .sdi_o(sdi));
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cycles++;
        if (syp === 1'b1) pulses++;
        if (oe === 1'b1) oe_cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end
    // ==========================================================
    // access and compare tasks
    task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        i_host.xfer(1'b0, a, d, 16, r);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] r;
        i_host.xfer(1'b1, a, 8'h00, 16, r);
        chk("readback", r, e);
    endtask
    task automatic endt(input string n);
        $display("test %s done", n);
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        rst_n_i = 1'b0;
        pin = 1'b0;
        refpin = 1'b0;
        gsleep = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        for (int i = 0; i < 4; i++) rd(ofs[i], 8'h00);
        chk("outputs", {offs, refsel}, 8'h00);
        chk("controls", {slp, pwr, sec, dco, sdl, azc}, 8'h00);
        chk("sdo enable", {7'h00, oe}, 8'h00);
        chk("sdo driven", {7'h00, oe_cycles > 0}, 8'h01);
        endt("reset");
        oe_cycles = 0;
        for (int i = 0; i < 6; i++) begin
            wr(`PSR_OFS_OUT_PWR, 8'h01 << i);
            chk("buffers", {2'b00, offs}, 8'h01 << i);
        end
        chk("sdo in writes", 8'(oe_cycles), 8'h00);
        wr(`PSR_OFS_OUT_PWR, 8'hFF);
        rd(`PSR_OFS_OUT_PWR, 8'hFF);
        chk("buffers", {2'b00, offs}, 8'h3F);
        i_host.xfer(1'b0, `PSR_OFS_OUT_PWR, 8'h00, 10, q);
        rd(`PSR_OFS_OUT_PWR, 8'hFF);
        wr(7'h10, 8'h5A);
        rd(7'h10, 8'h00);
        endt("buffers");
        gsleep = 1'b1;
        for (int i = 0; i < 8; i++) begin
            mk = 3'(i);
            wr(`PSR_OFS_MASK, {4'h0, mk, 1'b0});
            chk("mask", {5'h00, pwr}, {5'h00, ~mk[2:1], mk[0]});
        end
        rd(`PSR_OFS_MASK, 8'h0E);
        gsleep = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        chk("sleep blocks", {4'h0, slp, pwr}, 8'h00);
        endt("mask");
        pulses = 0;
        pin = 1'b1;
        repeat (8) @(negedge sys_clk_i);
        chk("pin sleep", {7'h00, slp}, 8'h01);
        pin = 1'b0;
        repeat (8) @(negedge sys_clk_i);
        wr(`PSR_OFS_CTL, 8'h80);
        pin = 1'b1;
        repeat (8) @(negedge sys_clk_i);
        chk("pin sleep", {7'h00, slp}, 8'h00);
        pin = 1'b0;
        repeat (8) @(negedge sys_clk_i);
        chk("sync count", 8'(pulses), 8'h01);
        pulses = 0;
        for (int i = 0; i < 6; i++) wr(`PSR_OFS_CTL, seq[i]);
        chk("sync count", 8'(pulses), 8'h02);
        wr(`PSR_OFS_CTL, 8'hA0);
        pin = 1'b1;
        repeat (8) @(negedge sys_clk_i);
        chk("pin sleep", {7'h00, slp}, 8'h00);
        pin = 1'b0;
        repeat (8) @(negedge sys_clk_i);
        chk("sync count", 8'(pulses), 8'h02);
        endt("sync");
        refpin = 1'b1;
        repeat (8) @(negedge sys_clk_i);
        chk("ref select", {6'h00, refsel}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(`PSR_OFS_CTL, 8'h08 | 8'(i << 1));
            chk("ref select", {6'h00, refsel}, 8'(i));
        end
        wr(`PSR_OFS_CTL, 8'h09);
        chk("clock select", {6'h00, sec, dco}, 8'h03);
        wr(`PSR_OFS_CTL, 8'h01);
        chk("clock select", {6'h00, sec, dco}, 8'h00);
        endt("reference");
        wr(`PSR_OFS_DLY, 8'h04);
        chk("delay", {5'h00, sdl, azc, azo}, 8'h04);
        wr(`PSR_OFS_DLY, 8'h01);
        chk("delay", {5'h00, sdl, azc, azo}, 8'h03);
        rd(`PSR_OFS_DLY, 8'h01);
        endt("delay");
        rst_n_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        chk("outputs", {offs, refsel}, 8'h01);
        for (int i = 0; i < 4; i++) rd(ofs[i], 8'h00);
        chk("controls", {slp, pwr, sec, dco, sdl, azc}, 8'h00);
        chk("auto zero on", {7'h00, azo}, 8'h00);
        endt("reset again");
        complete_run();
    end
endmodule
`default_nettype wire
